// ### hdl/dpram_defs.vh
// Functional notes
// - Inputs captured only on rising clock edge
// - Output enable high floats data asynchronously; the code registers it, so data floats at the third rising edge
// - Write self-timed from rising clock edge
// - Advance high holds address and data registers
// - Advance low loads address and data
// - Chip select high deselects, floats data
// - Pipelined reactivation needs two select-low cycles
// - Select and write low writes registered data
// - Read drives word, pipelined one cycle later
// - Write begins at edge, ends next edge
// - Left port always pipelined output
// - Right strap high pipelined, low flow-through
// - Pipelined pin state follows previous controls
// - Shared array 4K by 9, dual access
`ifndef DPRAM_DEFS_VH
`define DPRAM_DEFS_VH
`define ADDR_W 12
`define DATA_W 9
`define WORDS 4096
`define CWDD_NS 25
`define CLK_NS 25
`define CWDD_CYC ((`CWDD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### hdl/sync_dual_port_ram_ports.v
`timescale 1ns/1ps
`include "dpram_defs.vh"
// Both ports run on CLK. Pins are sampled through two flip-flops first.
module sync_dual_port_ram_ports #(
    parameter AW = `ADDR_W,
    parameter DW = `DATA_W,
    parameter WORDS = `WORDS
) (
    // Clock and reset
    input wire CLK,
    input wire RESET_N,
    // Left port
    input wire [AW-1:0] L_ADDR,
    input wire [DW-1:0] L_DATA_IN,
    input wire L_CHIP_SEL_N,
    input wire L_READ_WRITE_N,
    input wire L_OUT_EN_N,
    input wire L_REGISTER_ADVANCE_N,
    output reg [DW-1:0] L_DATA_OUT,
    output reg L_DATA_OE,
    // Right port
    input wire [AW-1:0] R_ADDR,
    input wire [DW-1:0] R_DATA_IN,
    input wire R_CHIP_SEL_N,
    input wire R_READ_WRITE_N,
    input wire R_OUT_EN_N,
    input wire R_REGISTER_ADVANCE_N,
    input wire RIGHT_OUTPUT_STAGE_STRAP,
    output reg [DW-1:0] R_DATA_OUT,
    output reg R_DATA_OE
);
    localparam CW = AW + DW + 4;
    localparam integer HIDE_INT = `CWDD_CYC;
    localparam [3:0] HIDE_CYC = HIDE_INT[3:0];

    // Field decoders of a pin bundle: addr, data, cs_n, rw_n, oe_n, adv_n
    function [AW-1:0] f_addr;
        input [CW-1:0] s;
        begin
            f_addr = s[CW-1:DW+4];
        end
    endfunction

    function [DW-1:0] f_data;
        input [CW-1:0] s;
        begin
            f_data = s[DW+3:4];
        end
    endfunction

    function f_cs_n;
        input [CW-1:0] s;
        begin
            f_cs_n = s[3];
        end
    endfunction

    function f_rw_n;
        input [CW-1:0] s;
        begin
            f_rw_n = s[2];
        end
    endfunction

    function f_oe_n;
        input [CW-1:0] s;
        begin
            f_oe_n = s[1];
        end
    endfunction

    function f_adv_n;
        input [CW-1:0] s;
        begin
            f_adv_n = s[0];
        end
    endfunction

    // Registered command decode
    function f_is_write;
        input cs_n;
        input rw_n;
        begin
            f_is_write = ~cs_n & ~rw_n;
        end
    endfunction

    function f_is_read;
        input cs_n;
        input rw_n;
        begin
            f_is_read = ~cs_n & rw_n;
        end
    endfunction

    // Shared array
    reg [DW-1:0] mem [0:WORDS-1];

    // Raw pin bundles
    wire [CW-1:0] l_pin = {L_ADDR, L_DATA_IN, L_CHIP_SEL_N, L_READ_WRITE_N, L_OUT_EN_N,
        L_REGISTER_ADVANCE_N};
    wire [CW-1:0] r_pin = {R_ADDR, R_DATA_IN, R_CHIP_SEL_N, R_READ_WRITE_N, R_OUT_EN_N,
        R_REGISTER_ADVANCE_N};

    // Two-stage synchronisers on every pin
    reg [CW-1:0] l_meta_ff;
    reg [CW-1:0] l_sync_ff;
    reg [CW-1:0] r_meta_ff;
    reg [CW-1:0] r_sync_ff;
    reg strap_meta_ff;
    reg strap_sync_ff;
    always @(posedge CLK) begin
        l_meta_ff <= l_pin;
        l_sync_ff <= l_meta_ff;
        r_meta_ff <= r_pin;
        r_sync_ff <= r_meta_ff;
        strap_meta_ff <= RIGHT_OUTPUT_STAGE_STRAP;
        strap_sync_ff <= strap_meta_ff;
    end

    // Synchronised fields
    wire [AW-1:0] l_s_addr = f_addr(l_sync_ff);
    wire [DW-1:0] l_s_data = f_data(l_sync_ff);
    wire l_s_cs_n = f_cs_n(l_sync_ff);
    wire l_s_rw_n = f_rw_n(l_sync_ff);
    wire l_s_oe_n = f_oe_n(l_sync_ff);
    wire l_s_adv_n = f_adv_n(l_sync_ff);
    wire [AW-1:0] r_s_addr = f_addr(r_sync_ff);
    wire [DW-1:0] r_s_data = f_data(r_sync_ff);
    wire r_s_cs_n = f_cs_n(r_sync_ff);
    wire r_s_rw_n = f_rw_n(r_sync_ff);
    wire r_s_oe_n = f_oe_n(r_sync_ff);
    wire r_s_adv_n = f_adv_n(r_sync_ff);

    // Port registers
    reg [AW-1:0] l_addr_ff;
    reg [AW-1:0] r_addr_ff;
    reg [DW-1:0] l_din_ff;
    reg [DW-1:0] r_din_ff;
    reg l_cs_n_ff;
    reg r_cs_n_ff;
    reg l_rw_n_ff;
    reg r_rw_n_ff;
    reg l_sel_ff;
    reg r_sel_ff;
    reg l_rd_ff;
    reg r_rd_ff;
    reg l_rdq_ff;
    reg r_rdq_ff;
    reg [DW-1:0] l_rdata_ff;
    reg [DW-1:0] r_rdata_ff;
    reg r_pipe_ff;
    // Cycles left before a cross-port write may be read back
    reg [3:0] l_hide_ff;
    reg [3:0] r_hide_ff;
    reg nxt_l_oe;
    reg nxt_r_oe;

    wire l_wr = f_is_write(l_cs_n_ff, l_rw_n_ff);
    wire r_wr = f_is_write(r_cs_n_ff, r_rw_n_ff);
    wire l_rd = f_is_read(l_cs_n_ff, l_rw_n_ff);
    wire r_rd = f_is_read(r_cs_n_ff, r_rw_n_ff);
    wire l_clash = r_wr & (r_addr_ff == l_addr_ff);
    wire r_clash = l_wr & (l_addr_ff == r_addr_ff);
    wire l_rd_ok = l_rd & ~l_clash & (l_hide_ff == 4'h0);
    wire r_rd_ok = r_rd & ~r_clash & (r_hide_ff == 4'h0);

    // Both ports write at once; same address leaves the right word
    always @(posedge CLK) begin
        if (l_wr)
            mem[l_addr_ff] <= l_din_ff;
        if (r_wr)
            mem[r_addr_ff] <= r_din_ff;
    end

    // Left port input and read pipeline
    always @(posedge CLK) begin
        if (!RESET_N) begin
            l_addr_ff <= {AW{1'b0}};
            l_din_ff <= {DW{1'b0}};
            l_cs_n_ff <= 1'b1;
            l_rw_n_ff <= 1'b1;
            l_sel_ff <= 1'b0;
            l_rd_ff <= 1'b0;
            l_rdq_ff <= 1'b0;
            l_rdata_ff <= {DW{1'b0}};
            l_hide_ff <= 4'h0;
        end else begin
            if (!l_s_adv_n) begin
                l_addr_ff <= l_s_addr;
                l_din_ff <= l_s_data;
            end
            l_cs_n_ff <= l_s_cs_n;
            l_rw_n_ff <= l_s_rw_n;
            l_sel_ff <= ~l_cs_n_ff;
            if (l_clash)
                l_hide_ff <= HIDE_CYC;
            else if (l_hide_ff != 4'h0)
                l_hide_ff <= l_hide_ff - 4'h1;
            l_rd_ff <= l_rd_ok;
            l_rdq_ff <= l_rd_ok & l_sel_ff;
            if (l_rd_ok)
                l_rdata_ff <= mem[l_addr_ff];
        end
    end

    // Right port input and read pipeline
    always @(posedge CLK) begin
        if (!RESET_N) begin
            r_addr_ff <= {AW{1'b0}};
            r_din_ff <= {DW{1'b0}};
            r_cs_n_ff <= 1'b1;
            r_rw_n_ff <= 1'b1;
            r_sel_ff <= 1'b0;
            r_rd_ff <= 1'b0;
            r_rdq_ff <= 1'b0;
            r_rdata_ff <= {DW{1'b0}};
            r_hide_ff <= 4'h0;
            r_pipe_ff <= 1'b1;
        end else begin
            r_pipe_ff <= strap_sync_ff;
            if (!r_s_adv_n) begin
                r_addr_ff <= r_s_addr;
                r_din_ff <= r_s_data;
            end
            r_cs_n_ff <= r_s_cs_n;
            r_rw_n_ff <= r_s_rw_n;
            r_sel_ff <= ~r_cs_n_ff;
            if (r_clash)
                r_hide_ff <= HIDE_CYC;
            else if (r_hide_ff != 4'h0)
                r_hide_ff <= r_hide_ff - 4'h1;
            r_rd_ff <= r_rd_ok;
            r_rdq_ff <= r_rd_ok & r_sel_ff;
            if (r_rd_ok)
                r_rdata_ff <= mem[r_addr_ff];
        end
    end

    // Enables are re-registered so the pins stay flop-driven
    always @* begin
        nxt_l_oe = l_rdq_ff & ~l_s_oe_n;
        if (r_pipe_ff)
            nxt_r_oe = r_rdq_ff & ~r_s_oe_n;
        else
            nxt_r_oe = r_rd_ff & ~r_s_oe_n;
    end

    always @(posedge CLK) begin
        if (!RESET_N) begin
            L_DATA_OUT <= {DW{1'b0}};
            L_DATA_OE <= 1'b0;
            R_DATA_OUT <= {DW{1'b0}};
            R_DATA_OE <= 1'b0;
        end else begin
            L_DATA_OUT <= l_rdata_ff;
            L_DATA_OE <= nxt_l_oe;
            R_DATA_OUT <= r_rdata_ff;
            R_DATA_OE <= nxt_r_oe;
        end
    end
endmodule // sync_dual_port_ram_ports

// ### tb/port_master.sv
`timescale 1ns/1ps
module port_master (
    // Pins of one port
    input wire clk,
    output logic [11:0] addr,
    output logic [8:0] din,
    output logic cs_n, rw_n, oe_n, adv_n
);
    // Deselected, outputs off, registers loading from the first edge
    initial {cs_n, rw_n, oe_n, adv_n, addr, din} = 25'h1400000;
    task op(input logic s, w, h, o, input logic [11:0] a, input logic [8:0] d, input int n);
        @(negedge clk);
        {cs_n, rw_n, adv_n, oe_n, addr, din} = {s, w, h, o, a, d};
        repeat (n) @(negedge clk);
        {cs_n, addr, din} = {1'b1, ~a, ~d};
    endtask
endmodule // port_master

// ### tb/ram_ports_sva.sv
`timescale 1ns/1ps
module ram_ports_sva (
    // Watched pins
    input wire CLK, RESET_N, RIGHT_OUTPUT_STAGE_STRAP,
    input wire L_CHIP_SEL_N, L_READ_WRITE_N, L_OUT_EN_N, L_DATA_OE,
    input wire R_CHIP_SEL_N, R_READ_WRITE_N, R_OUT_EN_N, R_DATA_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    l_idle_a: assert property (L_CHIP_SEL_N [*8] |-> !L_DATA_OE) else $error("left idle");
    r_idle_a: assert property (R_CHIP_SEL_N [*8] |-> !R_DATA_OE) else $error("right idle");
    l_float_a: assert property (L_OUT_EN_N [*8] |-> !L_DATA_OE) else $error("left off");
    r_float_a: assert property (R_OUT_EN_N [*8] |-> !R_DATA_OE) else $error("right off");
    l_write_a: assert property ((!L_READ_WRITE_N) [*8] |-> !L_DATA_OE) else $error("left wr");
    r_write_a: assert property ((!R_READ_WRITE_N) [*8] |-> !R_DATA_OE) else $error("right wr");
    l_wake_a: assert property (
        L_CHIP_SEL_N [*6] ##1 !L_CHIP_SEL_N ##1 L_CHIP_SEL_N [*6] |-> !L_DATA_OE) else $error("left");
    r_wake_a: assert property (RIGHT_OUTPUT_STAGE_STRAP throughout
        (R_CHIP_SEL_N [*6] ##1 !R_CHIP_SEL_N ##1 R_CHIP_SEL_N [*6]) |-> !R_DATA_OE) else $error("right");
endmodule // ram_ports_sva
bind sync_dual_port_ram_ports ram_ports_sva SVA (.*);

// ### tb/sync_dual_port_ram_ports_tb.sv
`timescale 1ns/1ps
module sync_dual_port_ram_ports_tb;
    logic CLK = 0, RESET_N = 0, RIGHT_OUTPUT_STAGE_STRAP = 0, L_DATA_OE, R_DATA_OE;
    logic [11:0] L_ADDR, R_ADDR, a;
    logic [8:0] L_DATA_IN, R_DATA_IN, L_DATA_OUT, R_DATA_OUT, d;
    logic L_CHIP_SEL_N, L_READ_WRITE_N, L_OUT_EN_N, L_REGISTER_ADVANCE_N;
    logic R_CHIP_SEL_N, R_READ_WRITE_N, R_OUT_EN_N, R_REGISTER_ADVANCE_N;
    int n_errors = 0, compares = 0;
    integer seed = 32'h57519A6B;
    port_master LM (.clk(CLK), .addr(L_ADDR), .din(L_DATA_IN), .cs_n(L_CHIP_SEL_N),
        .rw_n(L_READ_WRITE_N), .oe_n(L_OUT_EN_N), .adv_n(L_REGISTER_ADVANCE_N));
    port_master RM (.clk(CLK), .addr(R_ADDR), .din(R_DATA_IN), .cs_n(R_CHIP_SEL_N),
        .rw_n(R_READ_WRITE_N), .oe_n(R_OUT_EN_N), .adv_n(R_REGISTER_ADVANCE_N));
    sync_dual_port_ram_ports DUT (.*);
    initial forever #12.5 CLK = ~CLK;
    task test_done;
        if (n_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string s, input logic [8:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    // Read held nine cycles; counts falling edges until the port drives
    task rd(input bit r, input logic [11:0] x, input logic [8:0] e, input int lat, input bit h,
        input bit o);
        int c;
        c = 0;
        fork
            if (r) RM.op(0, 1, h, o, x, 0, 9); else LM.op(0, 1, h, o, x, 0, 9);
            begin
                @(negedge CLK);
                while ((r ? R_DATA_OE : L_DATA_OE) !== 1'b1 && c < 12) begin
                    @(negedge CLK);
                    c++;
                end
                chk("latency", lat, c);
                chk("data", e, r ? R_DATA_OUT : L_DATA_OUT);
            end
        join
    endtask
    initial begin
        #50000;
        n_errors++;
        test_done;
    end
    initial begin
        repeat (6) @(negedge CLK);
        RESET_N = 1;
        repeat (9) @(negedge CLK);
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 12'hFFF : $random(seed);
            d = (i == 0) ? 9'h1FF : $random(seed);
            RIGHT_OUTPUT_STAGE_STRAP = i[0];
            LM.op(0, 0, 0, 0, a, d, 1);
            repeat (8) @(negedge CLK);
            rd(0, a, d, 6, 0, 0);
            rd(1, a, d, 5 + i[0], 0, 0);
        end
        repeat (8) @(negedge CLK);
        rd(0, a, d, 12, 0, 1);
        RM.op(0, 0, 0, 0, ~a, ~d, 1);
        LM.op(0, 0, 0, 0, a, d, 1);
        repeat (8) @(negedge CLK);
        rd(0, 12'h000, ~d, 6, 1, 0);
        test_done;
    end
endmodule // sync_dual_port_ram_ports_tb
